// *** core/cce_ctrl.sv ***
// control, status and otp programming logic of the crypto engine, apb slave
//
// Overview of operation
// (R1) decode operation select, others reserved
// (R2) engine select: 1 aes, 0 des
// (R3) chaining select codes; 101, 11x reserved
// (R4) fields clear on reset and power-down
// (R5) go locks operation and key fields except key half select
// (R6) idle-halt stops operation on system idle
// (R7) counter mode increments masked counter, wraps
// (R8) key half select picks upper/lower half
// (R9) des key length codes, 10 reserved
// (R10) aes key length codes, 11 reserved
// (R11) busy while crypto or otp runs
// (R12) text a busy while block in use
// (R13) abort on software go clear, blocks go
// (R14) wrap flag blocks go until cleared
// (R15) mode/key invalid flags block program
// (R16) locked or reserved page blocks program
// (R17) invalid flags evaluate while module disabled
// (R18) otp read forces busy, key invalid and program invalid flags
// (R19) page select: 0 config, 1-8 keys
// (R20) program writes text c, reload reads
// (R21) software sequences program and reload safely
// (R22) otp done interrupt, test fuse mirror
// (R23) go starts operation, clears on done
// (R24) done interrupt on operation completion
// (R25) flags re-evaluated within one cycle
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "cce_regs.svh"
module cce_ctrl #(
    parameter int OTP_PGM_CYCLES = (`CCE_OTP_PGM_NS + `CCE_CLK_NS - 1) / `CCE_CLK_NS,
    parameter int OTP_RD_CYCLES = (`CCE_OTP_RD_NS + `CCE_CLK_NS - 1) / `CCE_CLK_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [4:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sys_idle,
    input wire logic eng_done,
    input wire logic eng_text_consumed,
    input wire logic [63:0] text_block_c,
    output logic eng_start,
    output logic eng_stop,
    output logic [3:0] operation_select,
    output logic engine_select,
    output logic [2:0] chaining_select,
    output logic key_half_select,
    output logic [1:0] key_length_select,
    output logic [3:0] key_source_select,
    output logic [127:0] counter_value,
    output logic engine_busy,
    output logic done_irq,
    output logic otp_irq
);
    import cce_pkg::*;

    cce_state_s q;
    cce_state_s n;
    cce_otp_if otp ();

    // ==================================================
    // configuration checks
    function automatic logic mode_bad(input logic [3:0] op, input logic eng,
                                      input logic [2:0] ch);
        logic op_ok;
        op_ok = (op == CCE_OP_ENC) || (op == CCE_OP_DEC) || (op == CCE_OP_RNG) ||
                (op == CCE_OP_SKENC) || (op == CCE_OP_SKLD) ||
                (op == CCE_OP_KEXP && eng); // R1 R2
        return !op_ok || (ch > CCE_CH_CTR); // R3
    endfunction

    function automatic logic key_bad(input logic eng, input logic [1:0] kl,
                                     input logic [3:0] ks, input logic [31:0] cfg);
        logic kl_bad;
        kl_bad = eng ? (kl == 2'h3) : (kl == 2'h2); // R9 R10
        return kl_bad || (ks == 4'h0 && cfg[`CCE_CFG_SWKEYDIS]) ||
               (ks >= 4'h8 && ks != 4'hf);
    endfunction

    function automatic logic page_bad(input logic [3:0] pg, input logic [31:0] cfg);
        if (pg > CCE_LAST_PAGE) begin // R19
            return 1'b1;
        end
        return cfg[`CCE_CFG_WRLOCK_LO + 32'(pg)]; // R16
    endfunction

    // ==================================================
    // apb decode
    logic acc;
    logic wr;
    logic [127:0] ctr_mask;
    logic [127:0] ctr_inc;

    assign acc = psel && penable && q.pready;
    assign wr = acc && pwrite && !q.pslverr;
    assign ctr_mask = (128'h1 << (8'(q.counter_width) + 8'h1)) - 128'h1;
    assign ctr_inc = (q.ctr + 128'h1) & ctr_mask;

    always_comb begin
        n = q;
        n.idle_s1 = sys_idle;
        n.idle_s2 = q.idle_s1;
        n.eng_start = 1'b0;
        n.eng_stop = 1'b0;
        n.done_irq = 1'b0;
        n.otp_irq = 1'b0;

        // --------------------------------------------------
        // register writes; locked fields hold while go is set
        if (wr && paddr == `CCE_OFF_CONL) begin
            n.module_on = pwdata[`CCE_CONL_ON];
            n.idle_halt = pwdata[`CCE_CONL_IDLE];
            n.done_irq_enable = pwdata[`CCE_CONL_DONE_IRQ_ENABLE];
            if (!q.operation_go) begin // R5
                n.operation_select = pwdata[`CCE_CONL_OP_HI:`CCE_CONL_OP_LO];
                n.engine_select = pwdata[`CCE_CONL_ENG];
                n.chaining_select = pwdata[`CCE_CONL_CH_HI:`CCE_CONL_CH_LO];
                if (pwdata[`CCE_CONL_GO] && q.module_on && !q.abort_flag &&
                    !q.counter_wrap_flag) begin // R13 R14
                    n.operation_go = 1'b1; // R23
                    n.eng_start = 1'b1;
                    n.text_a_busy_flag = 1'b1; // R12
                end
            end else if (!pwdata[`CCE_CONL_GO] && !eng_done) begin
                // software stop before completion
                n.operation_go = 1'b0; // R23
                n.eng_stop = 1'b1;
                n.abort_flag = 1'b1; // R13
                n.text_a_busy_flag = 1'b0;
                n.otp_program = 1'b0; // R20
            end
        end
        if (wr && paddr == `CCE_OFF_CONH) begin
            n.key_half_select = pwdata[`CCE_CONH_KHALF]; // R8
            if (!q.operation_go) begin // R5
                n.counter_width = pwdata[`CCE_CONH_CW_HI:`CCE_CONH_CW_LO];
                n.key_length_select = pwdata[`CCE_CONH_KL_HI:`CCE_CONH_KL_LO];
                n.key_source_select = pwdata[`CCE_CONH_KS_HI:`CCE_CONH_KS_LO];
            end
        end
        if (wr && paddr == `CCE_OFF_STAT) begin
            if (!pwdata[`CCE_STAT_ABORT]) begin
                n.abort_flag = 1'b0; // R13
            end
            if (!pwdata[`CCE_STAT_WRAP]) begin
                n.counter_wrap_flag = 1'b0; // R14
            end
        end
        if (wr && paddr == `CCE_OFF_OTP) begin
            n.otp_done_irq_enable = pwdata[`CCE_OTP_IE];
            if (q.otp_phase == OTP_IDLE) begin
                n.otp_page_select = pwdata[`CCE_OTP_PG_HI:`CCE_OTP_PG_LO];
            end
            // only a set is taken; the bits clear themselves when done
            if (pwdata[`CCE_OTP_PROG] && !q.mode_invalid_flag && !q.key_invalid_flag &&
                !page_bad(n.otp_page_select, q.cfg) && q.otp_phase == OTP_IDLE) begin // R15 R16
                n.otp_program = 1'b1;
            end
            if (pwdata[`CCE_OTP_RELOAD]) begin
                n.otp_reload = 1'b1; // R20
            end
        end
        if (wr && paddr == `CCE_OFF_PWR) begin
            n.module_power_down = pwdata[0];
        end

        // --------------------------------------------------
        // engine completion, idle halt and text block release
        if (q.operation_go && eng_done) begin
            n.operation_go = 1'b0; // R23
            n.abort_flag = 1'b0; // R13
            n.text_a_busy_flag = 1'b0;
            n.done_irq = q.done_irq_enable; // R24
            if (q.chaining_select == CCE_CH_CTR) begin // R7
                n.ctr = (q.ctr & ~ctr_mask) | ctr_inc;
                if (ctr_inc == 128'h0) begin
                    n.counter_wrap_flag = 1'b1; // R14
                end
            end
        end else if (q.operation_go && q.idle_halt && q.idle_s2) begin
            n.operation_go = 1'b0; // R6
            n.eng_stop = 1'b1;
            n.text_a_busy_flag = 1'b0;
        end
        if (eng_text_consumed) begin
            n.text_a_busy_flag = 1'b0; // R12
        end

        // --------------------------------------------------
        // otp sequencer: program wins if software broke the one-at-a-time rule
        case (q.otp_phase)
            OTP_IDLE: begin
                n.otp_cnt = 16'h0;
                if (q.otp_program) begin
                    n.otp_phase = OTP_PGM;
                end else if (q.otp_reload) begin
                    n.otp_phase = OTP_RD; // R18
                end
            end
            OTP_PGM: begin
                n.otp_cnt = q.otp_cnt + 16'h1;
                if (!q.otp_program) begin
                    n.otp_phase = OTP_IDLE;
                end else if (q.otp_cnt == 16'(OTP_PGM_CYCLES - 1)) begin
                    n.otp_program = 1'b0; // R20
                    n.otp_phase = OTP_IDLE;
                    n.otp_irq = q.otp_done_irq_enable; // R22
                end
            end
            OTP_RD: begin
                n.otp_cnt = q.otp_cnt + 16'h1;
                if (q.otp_cnt == 16'(OTP_RD_CYCLES - 1)) begin
                    n.cfg = otp.rdata[31:0];
                    n.otp_reload = 1'b0; // R20
                    n.otp_phase = OTP_IDLE;
                    n.otp_irq = q.otp_done_irq_enable; // R22
                end
            end
            default: begin
                n.otp_phase = OTP_IDLE;
            end
        endcase

        // --------------------------------------------------
        // power-down holds the fields at zero
        if (q.module_power_down) begin // R4
            n.operation_go = 1'b0;
            n.idle_halt = 1'b0;
            n.done_irq_enable = 1'b0;
            n.operation_select = 4'h0;
            n.engine_select = 1'b0;
            n.chaining_select = 3'h0;
            n.counter_width = 7'h0;
            n.key_half_select = 1'b0;
            n.key_length_select = 2'h0;
            n.key_source_select = 4'h0;
            n.abort_flag = 1'b0;
            n.counter_wrap_flag = 1'b0;
            n.otp_done_irq_enable = 1'b0;
            n.otp_page_select = 4'h0;
            n.otp_program = 1'b0;
        end

        // checks run on the next field values regardless of module_on
        n.mode_invalid_flag = mode_bad(n.operation_select, n.engine_select,
                                       n.chaining_select); // R15 R17 R25
        n.key_invalid_flag = (n.otp_phase == OTP_RD) ||
                             key_bad(n.engine_select, n.key_length_select,
                                     n.key_source_select, n.cfg); // R18 R25
        n.program_invalid_flag = (n.otp_phase == OTP_RD) ||
                                 page_bad(n.otp_page_select, n.cfg); // R16 R18
        n.engine_busy_flag = n.operation_go || (n.otp_phase != OTP_IDLE); // R11 R18

        // --------------------------------------------------
        // apb: answer in the cycle after setup, read data sampled at setup
        n.pready = psel && !penable;
        n.pslverr = psel && !penable && (paddr[1:0] != 2'h0 || paddr > `CCE_OFF_PWR);
        n.prdata = 32'h0;
        if (psel && !penable) begin
            case (paddr)
                `CCE_OFF_CONL: begin
                    n.prdata[`CCE_CONL_ON] = q.module_on;
                    n.prdata[`CCE_CONL_IDLE] = q.idle_halt;
                    n.prdata[`CCE_CONL_DONE_IRQ_ENABLE] = q.done_irq_enable;
                    n.prdata[`CCE_CONL_GO] = q.operation_go;
                    n.prdata[`CCE_CONL_OP_HI:`CCE_CONL_OP_LO] = q.operation_select;
                    n.prdata[`CCE_CONL_ENG] = q.engine_select;
                    n.prdata[`CCE_CONL_CH_HI:`CCE_CONL_CH_LO] = q.chaining_select;
                end
                `CCE_OFF_CONH: begin
                    n.prdata[`CCE_CONH_CW_HI:`CCE_CONH_CW_LO] = q.counter_width;
                    n.prdata[`CCE_CONH_KHALF] = q.key_half_select;
                    n.prdata[`CCE_CONH_KL_HI:`CCE_CONH_KL_LO] = q.key_length_select;
                    n.prdata[`CCE_CONH_KS_HI:`CCE_CONH_KS_LO] = q.key_source_select;
                end
                `CCE_OFF_STAT: begin
                    n.prdata[7:0] = {q.engine_busy_flag, q.text_a_busy_flag, q.abort_flag,
                                     q.counter_wrap_flag, 1'b0, q.mode_invalid_flag,
                                     q.key_invalid_flag, q.program_invalid_flag};
                end
                `CCE_OFF_OTP: begin
                    n.prdata[7] = q.cfg[`CCE_CFG_TSTFUSE]; // R22
                    n.prdata[`CCE_OTP_IE] = q.otp_done_irq_enable;
                    n.prdata[`CCE_OTP_RELOAD] = q.otp_reload;
                    n.prdata[`CCE_OTP_PG_HI:`CCE_OTP_PG_LO] = q.otp_page_select;
                    n.prdata[`CCE_OTP_PROG] = q.otp_program;
                end
                `CCE_OFF_PWR: begin
                    n.prdata[0] = q.module_power_down;
                end
                default: begin
                    n.prdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.otp_reload <= `CCE_RELOAD_RST; // power-on reload of the array
            q.otp_phase <= OTP_RD;
            q.engine_busy_flag <= 1'b1;
            q.key_invalid_flag <= 1'b1;
            q.program_invalid_flag <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ==================================================
    // otp store
    assign otp.we = (q.otp_phase == OTP_PGM) && q.otp_program &&
                    (q.otp_cnt == 16'(OTP_PGM_CYCLES - 1)); // R20
    assign otp.waddr = q.otp_page_select;
    assign otp.wdata = text_block_c;
    assign otp.raddr = 4'h0;

    cce_otp_mem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .otp(otp.mem)
    );

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign eng_start = q.eng_start;
    assign eng_stop = q.eng_stop;
    assign operation_select = q.operation_select;
    assign engine_select = q.engine_select;
    assign chaining_select = q.chaining_select;
    assign key_half_select = q.key_half_select;
    assign key_length_select = q.key_length_select;
    assign key_source_select = q.key_source_select;
    assign counter_value = q.ctr;
    assign engine_busy = q.engine_busy_flag;
    assign done_irq = q.done_irq;
    assign otp_irq = q.otp_irq;

    // ==================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic wr_conl;
    assign wr_conl = wr && paddr == `CCE_OFF_CONL;

    a_wrap_blocks_go: assert property (wr_conl && pwdata[`CCE_CONL_GO] && !q.operation_go &&
        q.counter_wrap_flag |=> !q.operation_go) else $error("go set while wrap flag"); // R14
    a_abort_on_stop: assert property (wr_conl && !pwdata[`CCE_CONL_GO] && q.operation_go &&
        !eng_done && !q.module_power_down |=> q.abort_flag && !q.operation_go)
        else $error("software stop did not abort"); // R13
    a_done_clears_go: assert property (q.operation_go && eng_done && !q.module_power_down
        |=> !q.operation_go && !q.abort_flag) else $error("done left go set"); // R23
    a_busy_tracks: assert property (q.engine_busy_flag ==
        (q.operation_go || q.otp_phase != OTP_IDLE)) else $error("busy flag mismatch"); // R11
    a_read_forces: assert property (q.otp_phase == OTP_RD |->
        q.key_invalid_flag && q.program_invalid_flag) else $error("read not forcing flags"); // R18
    a_page_refused: assert property (wr && paddr == `CCE_OFF_OTP && pwdata[`CCE_OTP_PROG] &&
        pwdata[`CCE_OTP_PG_HI:`CCE_OTP_PG_LO] > CCE_LAST_PAGE && !q.otp_program |=> !q.otp_program)
        else $error("program accepted on bad page"); // R16
    a_mode_reserved: assert property (q.chaining_select > CCE_CH_CTR |-> q.mode_invalid_flag)
        else $error("reserved chaining not flagged"); // R3
    a_pd_clears: assert property (q.module_power_down |=> q.operation_select == 4'h0 &&
        !q.operation_go && q.otp_page_select == 4'h0) else $error("power-down kept fields"); // R4
    a_pgm_length: assert property ($rose(q.otp_phase == OTP_PGM) |->
        (q.otp_program && q.otp_phase == OTP_PGM)[*2]) else $error("program ended early"); // R20
endmodule

// *** core/cce_regs.svh ***
// register offsets, field positions, reset values and timing of the crypto control block
`ifndef CCE_REGS_SVH
`define CCE_REGS_SVH

// ==================================================
// register byte offsets (paddr[4:0])
`define CCE_OFF_CONL 5'h00
`define CCE_OFF_CONH 5'h04
`define CCE_OFF_STAT 5'h08
`define CCE_OFF_OTP 5'h0c
`define CCE_OFF_PWR 5'h10

// ==================================================
// control low fields
`define CCE_CONL_ON 15
`define CCE_CONL_IDLE 13
`define CCE_CONL_DONE_IRQ_ENABLE 11
`define CCE_CONL_GO 8
`define CCE_CONL_OP_HI 7
`define CCE_CONL_OP_LO 4
`define CCE_CONL_ENG 3
`define CCE_CONL_CH_HI 2
`define CCE_CONL_CH_LO 0

// control high fields
`define CCE_CONH_CW_HI 14
`define CCE_CONH_CW_LO 8
`define CCE_CONH_KHALF 7
`define CCE_CONH_KL_HI 6
`define CCE_CONH_KL_LO 5
`define CCE_CONH_KS_HI 3
`define CCE_CONH_KS_LO 0

// status fields (software clears by writing 0)
`define CCE_STAT_ABORT 5
`define CCE_STAT_WRAP 4

// otp control fields
`define CCE_OTP_IE 6
`define CCE_OTP_RELOAD 5
`define CCE_OTP_PG_HI 4
`define CCE_OTP_PG_LO 1
`define CCE_OTP_PROG 0

// configuration page fields
`define CCE_CFG_TSTFUSE 30
`define CCE_CFG_WRLOCK_LO 1
`define CCE_CFG_SWKEYDIS 0

// ==================================================
// reset values and timing
`define CCE_RELOAD_RST 1'b1
`define CCE_CLK_NS 50
`define CCE_OTP_PGM_NS 2000
`define CCE_OTP_RD_NS 500

`endif

// *** core/cce_pkg.sv ***
// types shared by the crypto control block
package cce_pkg;

    // ==================================================
    // encodings
    typedef enum logic [1:0] {OTP_IDLE, OTP_PGM, OTP_RD} cce_otp_e;

    localparam logic [3:0] CCE_OP_ENC = 4'h0;
    localparam logic [3:0] CCE_OP_DEC = 4'h1;
    localparam logic [3:0] CCE_OP_KEXP = 4'h2;
    localparam logic [3:0] CCE_OP_RNG = 4'ha;
    localparam logic [3:0] CCE_OP_SKENC = 4'he;
    localparam logic [3:0] CCE_OP_SKLD = 4'hf;
    localparam logic [2:0] CCE_CH_CTR = 3'h4;
    localparam logic [3:0] CCE_LAST_PAGE = 4'h8;

    // ==================================================
    // state of the control module
    typedef struct packed {
        logic idle_s1;
        logic idle_s2;
        logic module_on;
        logic idle_halt;
        logic done_irq_enable;
        logic operation_go;
        logic [3:0] operation_select;
        logic engine_select;
        logic [2:0] chaining_select;
        logic [6:0] counter_width;
        logic key_half_select;
        logic [1:0] key_length_select;
        logic [3:0] key_source_select;
        logic module_power_down;
        logic abort_flag;
        logic counter_wrap_flag;
        logic text_a_busy_flag;
        logic otp_done_irq_enable;
        logic [3:0] otp_page_select;
        logic otp_program;
        logic otp_reload;
        cce_otp_e otp_phase;
        logic [15:0] otp_cnt;
        logic [31:0] cfg;
        logic mode_invalid_flag;
        logic key_invalid_flag;
        logic program_invalid_flag;
        logic engine_busy_flag;
        logic [127:0] ctr;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic eng_start;
        logic eng_stop;
        logic done_irq;
        logic otp_irq;
    } cce_state_s;

    typedef struct packed {
        logic [8:0][63:0] arr;
        logic [63:0] rdata;
    } cce_mem_s;

endpackage

// *** core/cce_otp_if.sv ***
// link between the control logic and the otp key store
`timescale 1ns/100ps
interface cce_otp_if;
    logic we;
    logic [3:0] waddr;
    logic [63:0] wdata;
    logic [3:0] raddr;
    logic [63:0] rdata;

    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** core/cce_otp_mem.sv ***
// otp key store model: nine 64-bit pages, fuse-style write, registered read
`timescale 1ns/100ps
module cce_otp_mem (
    input wire logic pclk,
    input wire logic presetn,
    cce_otp_if.mem otp
);
    import cce_pkg::*;

    cce_mem_s q;
    cce_mem_s n;

    // ==================================================
    // a fuse can only go from 0 to 1, so a write ors into the page
    always_comb begin
        n = q;
        if (otp.we && otp.waddr <= CCE_LAST_PAGE) begin
            n.arr[otp.waddr] = q.arr[otp.waddr] | otp.wdata;
        end
        n.rdata = (otp.raddr <= CCE_LAST_PAGE) ? q.arr[otp.raddr] : 64'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign otp.rdata = q.rdata;
endmodule

// *** testbench/crypto_engine_control_status_test.sv ***
// self-checking bench for the crypto control and otp programming register block
`timescale 1ns/100ps
`include "cce_regs.svh"
module crypto_engine_control_status_test;
    import cce_pkg::*;
    typedef struct packed {logic [15:0] l; logic [15:0] h; logic [7:0] o; logic [2:0] s;} cce_row_s;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, eng_done, eng_start, eng_stop;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [63:0] text_block_c;
    logic [127:0] counter_value;
    logic engine_busy, done_irq, otp_irq, er;
    int n_fail = 0, checks_done = 0, n_start = 0, n_dirq = 0, n_oirq = 0;
    // mode codes first, then key length and source codes, then page codes; module stays off
    cce_row_s rows[22] = '{
        '{16'h0000, 16'h0000, 8'h00, 3'h0}, '{16'h0019, 16'h0000, 8'h00, 3'h0},
        '{16'h0020, 16'h0000, 8'h00, 3'h4}, '{16'h0028, 16'h0000, 8'h00, 3'h0},
        '{16'h00a0, 16'h0000, 8'h00, 3'h0}, '{16'h00e0, 16'h0000, 8'h00, 3'h0},
        '{16'h00f0, 16'h0000, 8'h00, 3'h0}, '{16'h0030, 16'h0000, 8'h00, 3'h4},
        '{16'h00b0, 16'h0000, 8'h00, 3'h4}, '{16'h0004, 16'h0000, 8'h00, 3'h0},
        '{16'h0005, 16'h0000, 8'h00, 3'h4}, '{16'h0006, 16'h0000, 8'h00, 3'h4},
        '{16'h0007, 16'h0000, 8'h00, 3'h4}, '{16'h0000, 16'h0040, 8'h00, 3'h2},
        '{16'h0000, 16'h0060, 8'h00, 3'h0}, '{16'h0008, 16'h0040, 8'h00, 3'h0},
        '{16'h0008, 16'h0060, 8'h00, 3'h2}, '{16'h0000, 16'h0008, 8'h00, 3'h2},
        '{16'h0000, 16'h000f, 8'h00, 3'h0}, '{16'h0000, 16'h0000, 8'h10, 3'h0},
        '{16'h0000, 16'h0000, 8'h12, 3'h1}, '{16'h0000, 16'h0000, 8'h1e, 3'h1}};

    cce_ctrl #(.OTP_PGM_CYCLES(4), .OTP_RD_CYCLES(8)) cce_ctrl_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_idle(1'b0),
        .eng_done(eng_done), .eng_text_consumed(1'b0), .text_block_c(text_block_c),
        .eng_start(eng_start), .eng_stop(eng_stop), .operation_select(), .engine_select(),
        .chaining_select(), .key_half_select(), .key_length_select(), .key_source_select(),
        .counter_value(counter_value), .engine_busy(engine_busy), .done_irq(done_irq),
        .otp_irq(otp_irq));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        n_start <= n_start + eng_start;
        n_dirq <= n_dirq + done_irq;
        n_oirq <= n_oirq + otp_irq;
    end

    // ==================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // request held until pready is sampled high; no wait-state count assumed
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input logic [4:0] a, input logic [31:0] m);
        for (int i = 0; i < 60 && (i == 0 || (rd & m) !== 32'h0); i++) apb(1'b0, a, 32'h0);
        chk("poll_clear", rd & m, 32'h0);
    endtask
    task automatic pulse();
        @(posedge pclk);
        eng_done <= 1'b1;
        @(posedge pclk);
        eng_done <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #3000000;
        n_fail++;
        wrap_up();
    end

    // ==================================================
    // main sequence
    initial begin
        {psel, penable, pwrite, eng_done, presetn} = 5'h0;
        paddr = 5'h00;
        pwdata = 32'h0;
        text_block_c = 64'h0123_4567_89ab_cdef;
        repeat (16) @(posedge pclk);
        chk("busy_in_reset", {31'h0, engine_busy}, 32'h1);
        presetn <= 1'b1;
        apb(1'b0, `CCE_OFF_STAT, 32'h0);
        chk("stat_auto_read", rd, 32'h83);
        poll(`CCE_OFF_OTP, 32'h20);
        apb(1'b0, `CCE_OFF_STAT, 32'h0);
        chk("stat_settled", rd, 32'h0);
        apb(1'b0, `CCE_OFF_CONH, 32'h0);
        chk("conh_reset", rd, 32'h0);
        apb(1'b0, 5'h14, 32'h0);
        chk("unmapped_err", {31'h0, er}, 32'h1);
        foreach (rows[i]) begin
            apb(1'b1, `CCE_OFF_CONL, {16'h0, rows[i].l});
            apb(1'b1, `CCE_OFF_CONH, {16'h0, rows[i].h});
            apb(1'b1, `CCE_OFF_OTP, {24'h0, rows[i].o});
            apb(1'b0, `CCE_OFF_STAT, 32'h0);
            chk("row_status", rd, {29'h0, rows[i].s});
            apb(1'b0, `CCE_OFF_CONL, 32'h0);
            chk("row_conl", rd, {16'h0, rows[i].l});
        end
        apb(1'b1, `CCE_OFF_OTP, 32'h0);
        apb(1'b1, `CCE_OFF_CONL, 32'h0100);
        apb(1'b0, `CCE_OFF_CONL, 32'h0);
        chk("go_when_off", rd, 32'h0);
        apb(1'b1, `CCE_OFF_CONL, 32'h8000);
        apb(1'b1, `CCE_OFF_CONL, 32'h8900);
        apb(1'b1, `CCE_OFF_CONL, 32'h8930);
        apb(1'b1, `CCE_OFF_CONH, 32'h0060);
        apb(1'b0, `CCE_OFF_CONL, 32'h0);
        chk("locked_conl", rd, 32'h8900);
        apb(1'b0, `CCE_OFF_CONH, 32'h0);
        chk("locked_conh", rd, 32'h0);
        apb(1'b0, `CCE_OFF_STAT, 32'h0);
        chk("busy_running", rd, 32'hc0);
        pulse();
        apb(1'b0, `CCE_OFF_CONL, 32'h0);
        chk("go_hw_clear", rd, 32'h8800);
        chk("start_and_done", {n_start[15:0], n_dirq[15:0]}, 32'h0001_0001);
        apb(1'b1, `CCE_OFF_CONL, 32'h8900);
        apb(1'b1, `CCE_OFF_CONL, 32'h8800);
        apb(1'b1, `CCE_OFF_CONL, 32'h8900);
        apb(1'b0, `CCE_OFF_STAT, 32'h0);
        chk("abort_set", rd, 32'h20);
        apb(1'b0, `CCE_OFF_CONL, 32'h0);
        chk("go_after_abort", rd, 32'h8800);
        apb(1'b1, `CCE_OFF_STAT, 32'h0);
        for (int k = 1; k <= 2; k++) begin
            apb(1'b1, `CCE_OFF_CONL, 32'h8904);
            pulse();
            apb(1'b0, `CCE_OFF_STAT, 32'h0);
            chk("ctr_low", counter_value[31:0], k % 2);
            chk("wrap_flag", rd, (k == 2) ? 32'h10 : 32'h0);
        end
        apb(1'b1, `CCE_OFF_CONL, 32'h8904);
        apb(1'b0, `CCE_OFF_CONL, 32'h0);
        chk("go_after_wrap", rd, 32'h8804);
        apb(1'b1, `CCE_OFF_STAT, 32'h0);
        apb(1'b1, `CCE_OFF_PWR, 32'h1);
        apb(1'b0, `CCE_OFF_CONL, 32'h0);
        chk("conl_power_down", rd, 32'h8000);
        apb(1'b1, `CCE_OFF_PWR, 32'h0);
        apb(1'b1, `CCE_OFF_CONL, 32'h8030);
        apb(1'b1, `CCE_OFF_OTP, 32'h03);
        apb(1'b0, `CCE_OFF_OTP, 32'h0);
        chk("prog_mode_bad", rd & 32'h1, 32'h0);
        apb(1'b1, `CCE_OFF_CONL, 32'h8000);
        apb(1'b1, `CCE_OFF_OTP, 32'h13);
        apb(1'b0, `CCE_OFF_OTP, 32'h0);
        chk("prog_page_bad", rd & 32'h1, 32'h0);
        text_block_c <= 64'h4000_0000;
        apb(1'b1, `CCE_OFF_OTP, 32'h41);
        apb(1'b0, `CCE_OFF_STAT, 32'h0);
        chk("busy_prog", rd & 32'h80, 32'h80);
        poll(`CCE_OFF_OTP, 32'h1);
        apb(1'b1, `CCE_OFF_OTP, 32'h60);
        apb(1'b0, `CCE_OFF_STAT, 32'h0);
        chk("stat_reload", rd & 32'h83, 32'h83);
        poll(`CCE_OFF_OTP, 32'h20);
        chk("otp_irq_count", n_oirq, 32'h2);
        apb(1'b0, `CCE_OFF_OTP, 32'h0);
        chk("test_fuse_mirror", rd & 32'h80, 32'h80);
        wrap_up();
    end
endmodule
